// ### inc/fault_irq_pkg.sv
// Shared constants and carrier types for the fault event latch and wake/interrupt block.
// Assumes one 10 MHz clock and comparator inputs that are already synchronous to it.
package fault_irq_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_EVENT  = 8'h00;
  localparam logic [7:0] ADDR_MASK   = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_MODE   = 8'h04;

  // ==========================================================================
  // Field positions, shared by event, mask and status bytes, plus the soft reset bit of the mode byte
  localparam int BIT_NOT_READY = 7;
  localparam int BIT_LINE      = 7;
  localparam int BIT_WAKE      = 6;
  localparam int BIT_AUX       = 6;
  localparam int BIT_DRV       = 4;
  localparam int BIT_WARN      = 3;
  localparam int BIT_UV        = 2;
  localparam int BIT_TSD       = 1;
  localparam int BIT_TW        = 0;
  localparam int BIT_SOFT_RST  = 7;

  // ==========================================================================
  // Reset values and writable bits
  localparam logic [7:0] EVENT_RESET   = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] MASK_WRITABLE = 8'h5F;
  localparam logic [4:0] SRC_ALL_MASK  = 5'h1F;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS     = 32'h0000_0064;
  localparam int unsigned NS_PER_US         = 32'h0000_03E8;
  localparam int unsigned WAKE_PULSE_US     = 32'h0000_00C8;
  localparam int unsigned WAKE_PULSE_CYCLES = WAKE_PULSE_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int          WAKE_CNT_W        = 12;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic line_low;
    logic aux_low;
    logic wake_detect;
    logic driver_fault;
    logic supply_below_warn;
    logic supply_below_uv_fall;
    logic supply_above_uv_rise;
    logic temp_above_shutdown;
    logic temp_above_warn_rise;
    logic temp_below_warn_fall;
  } sense_t;

  typedef struct packed {
    logic       not_ready;
    logic [7:0] mask;
    logic [7:0] status;
    logic       uv_hold;
    logic       tw_hold;
    logic [7:0] rdata;
    logic       irq_n;
  } core_state_t;

endpackage

// ### hdl/event_latch_bank.sv
// Bank of sticky event flags, each set by the rising edge of its trigger.
// Assumes triggers are synchronous levels; clear is a one-cycle pulse.
module event_latch_bank #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] trigger,
  input  wire logic         clear,
  output logic      [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] flags;
  } bank_state_t;

  bank_state_t  state_ff;
  bank_state_t  nxt_state;
  logic [W-1:0] set_now;

  // ==========================================================================
  // Edge detection per source.
  for (genvar i = 0; i < W; i++) begin : g_edge
    assign set_now[i] = trigger[i] & ~state_ff.prev[i];
  end

  // A new event beats a clear in the same cycle so it is never lost.
  always_comb begin
    nxt_state       = state_ff;
    nxt_state.prev  = trigger;
    nxt_state.flags = clear ? set_now : (state_ff.flags | set_now);
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign flags = state_ff.flags;

  chk_edge_latches:
  assert property (@(posedge clk) disable iff (sys_rst)
    (set_now != '0) |=> ((state_ff.flags & $past(set_now)) == $past(set_now)))
    else $error("Event edge did not latch its flag.");

endmodule

// ### hdl/wake_pulse_timer.sv
// Retriggerable one-shot that stays active for a fixed number of clock cycles.
// Assumes start and cancel are one-cycle pulses; cancel wins.
module wake_pulse_timer #(
  parameter int unsigned CYCLES = fault_irq_pkg::WAKE_PULSE_CYCLES,
  parameter int          CW     = fault_irq_pkg::WAKE_CNT_W
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start,
  input  wire logic cancel,
  output logic      active
);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          active;
  } timer_state_t;

  timer_state_t state_ff;
  timer_state_t nxt_state;

  // ==========================================================================
  // Load on start, count down while active, drop at zero.
  always_comb begin
    nxt_state = state_ff;
    if (cancel) begin
      nxt_state = '0;
    end else if (start) begin
      nxt_state.count  = CW'(CYCLES - 1);
      nxt_state.active = 1'b1;
    end else if (state_ff.active) begin
      if (state_ff.count == '0) begin
        nxt_state.active = 1'b0;
      end else begin
        nxt_state.count = state_ff.count - 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign active = state_ff.active;

endmodule

// ### hdl/fault_event_latch_irq.sv
// Event flags, masks and live status of a line transceiver, with the wake/interrupt output.
// Assumes the register port is the device's internal access port behind its serial interface,
// and that all comparator inputs are clean levels synchronous to clk.
//
// Operation
// - Not-ready flag sets on power-up, logic-supply register reset or register corruption.
// - Not-ready flag always drives the interrupt output; it has no mask bit.
// - Wake-up flag latches on each valid wake-up request on the line.
// - Driver fault flag latches on overcurrent, overload or driver thermal shutdown.
// - Supply warning flag latches when field supply falls below warning threshold.
// - Undervoltage flag latches when field supply falls below falling threshold.
// - Thermal shutdown flag latches when the device enters thermal shutdown.
// - Thermal warning flag latches when die rises above warning threshold.
// - Flags stay set until the event register is read; that read clears all.
// - Wake mask clear: flag drives output; set: output pulses about 200 us instead.
// - Mask bits 4..0 set keep their source flag off the interrupt output.
// - Status bits 7 and 6 show line and aux input levels inverted.
// - Status bit 4 shows a present driver fault, not latched.
// - Status bit 3 shows field supply below the warning threshold.
// - Status bit 2 shows undervoltage with hysteresis between falling and rising.
// - Status bit 1 shows the device is in thermal shutdown.
// - Status bit 0 shows thermal warning with hysteresis.
// - Writing one to bit 7 at 0x04 returns all registers to defaults.
module fault_event_latch_irq #(
  parameter int unsigned WAKE_PULSE_CYCLES = fault_irq_pkg::WAKE_PULSE_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire fault_irq_pkg::reg_req_t  reg_req,
  output logic [7:0]                    reg_rdata,
  input  wire fault_irq_pkg::sense_t    sense,
  input  wire logic                     logic_supply_reset,
  input  wire logic                     reg_corrupt,
  output logic                          wake_irq_n
);

  // ==========================================================================
  // Declarations
  fault_irq_pkg::core_state_t state_ff;
  fault_irq_pkg::core_state_t nxt_state;

  logic [7:0] triggers;
  logic [7:0] bank_flags;
  logic [7:0] ev_flags;
  logic       soft_rst;
  logic       reg_reset;
  logic       rd_event;
  logic       mask_wr;
  logic       bank_clear;
  logic       pulse_start;
  logic       pulse_active;
  logic       irq_active;

  // ==========================================================================
  // Register port decode
  // Decode of the one-cycle read and write strobes.
  assign soft_rst   = reg_req.wr && (reg_req.addr == fault_irq_pkg::ADDR_MODE)
                      && reg_req.wdata[fault_irq_pkg::BIT_SOFT_RST];
  assign reg_reset  = soft_rst || logic_supply_reset;
  assign rd_event   = reg_req.rd && (reg_req.addr == fault_irq_pkg::ADDR_EVENT);
  assign mask_wr    = reg_req.wr && (reg_req.addr == fault_irq_pkg::ADDR_MASK);
  assign bank_clear = rd_event || reg_reset;

  // ==========================================================================
  // Event sources
  // Each comparator level that starts an event is routed to its flag position.
  always_comb begin
    triggers                             = 8'h00;
    triggers[fault_irq_pkg::BIT_WAKE]    = sense.wake_detect;
    triggers[fault_irq_pkg::BIT_DRV]     = sense.driver_fault;
    triggers[fault_irq_pkg::BIT_WARN]    = sense.supply_below_warn;
    triggers[fault_irq_pkg::BIT_UV]      = sense.supply_below_uv_fall;
    triggers[fault_irq_pkg::BIT_TSD]     = sense.temp_above_shutdown;
    triggers[fault_irq_pkg::BIT_TW]      = sense.temp_above_warn_rise;
  end

  // Sticky flags, cleared together by a read of the event register.
  event_latch_bank #(
    .W (8)
  ) u_bank (
    .clk     (clk),
    .sys_rst (sys_rst),
    .trigger (triggers),
    .clear   (bank_clear),
    .flags   (bank_flags)
  );

  // The event byte as software sees it; bit 5 is reserved.
  always_comb begin
    ev_flags                               = bank_flags & ~8'h20;
    ev_flags[fault_irq_pkg::BIT_NOT_READY] = state_ff.not_ready;
  end

  // ==========================================================================
  // Wake pulse mode
  // In pulse mode a valid wake-up fires a fixed-length pulse on the output.
  assign pulse_start = sense.wake_detect && state_ff.mask[fault_irq_pkg::BIT_WAKE]
                       && !reg_reset;

  wake_pulse_timer #(
    .CYCLES (WAKE_PULSE_CYCLES),
    .CW     (fault_irq_pkg::WAKE_CNT_W)
  ) u_pulse (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (pulse_start),
    .cancel  (reg_reset),
    .active  (pulse_active)
  );

  // ==========================================================================
  // Interrupt request
  // Not-ready is never masked; wake flag counts only outside pulse mode.
  assign irq_active = state_ff.not_ready
    || (bank_flags[fault_irq_pkg::BIT_WAKE] && !state_ff.mask[fault_irq_pkg::BIT_WAKE])
    || pulse_active
    || ((bank_flags[4:0] & ~state_ff.mask[4:0]) != 5'h00);

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_state = state_ff;

    // Undervoltage hysteresis: set below falling, clear above rising threshold.
    if (sense.supply_below_uv_fall) begin
      nxt_state.uv_hold = 1'b1;
    end else if (sense.supply_above_uv_rise) begin
      nxt_state.uv_hold = 1'b0;
    end

    // Thermal warning hysteresis: set above rising, clear below falling temperature.
    if (sense.temp_above_warn_rise) begin
      nxt_state.tw_hold = 1'b1;
    end else if (sense.temp_below_warn_fall) begin
      nxt_state.tw_hold = 1'b0;
    end

    // Live status mirror; bit 5 stays zero.
    nxt_state.status                              = fault_irq_pkg::STATUS_RESET;
    nxt_state.status[fault_irq_pkg::BIT_LINE]     = sense.line_low;
    nxt_state.status[fault_irq_pkg::BIT_AUX]      = sense.aux_low;
    nxt_state.status[fault_irq_pkg::BIT_DRV]      = sense.driver_fault;
    nxt_state.status[fault_irq_pkg::BIT_WARN]     = sense.supply_below_warn;
    nxt_state.status[fault_irq_pkg::BIT_UV]       = nxt_state.uv_hold;
    nxt_state.status[fault_irq_pkg::BIT_TSD]      = sense.temp_above_shutdown;
    nxt_state.status[fault_irq_pkg::BIT_TW]       = nxt_state.tw_hold;

    // Mask register; reserved bits never store.
    if (reg_reset) begin
      nxt_state.mask = fault_irq_pkg::MASK_RESET;
    end else if (mask_wr) begin
      nxt_state.mask = reg_req.wdata & fault_irq_pkg::MASK_WRITABLE;
    end

    // Not-ready flag: a new cause wins over a clearing read.
    if (logic_supply_reset || reg_corrupt) begin
      nxt_state.not_ready = 1'b1;
    end else if (reg_reset || rd_event) begin
      nxt_state.not_ready = 1'b0;
    end

    // Read data, answered one cycle after the strobe and held until the next read.
    if (reg_req.rd) begin
      case (reg_req.addr)
        fault_irq_pkg::ADDR_EVENT:  nxt_state.rdata = ev_flags;
        fault_irq_pkg::ADDR_MASK:   nxt_state.rdata = state_ff.mask;
        fault_irq_pkg::ADDR_STATUS: nxt_state.rdata = state_ff.status;
        default:                    nxt_state.rdata = 8'h00;
      endcase
    end

    // Output is registered from the current flags.
    nxt_state.irq_n = ~irq_active;
  end

  // ==========================================================================
  // State register
  // Power-up leaves not-ready set; the output is released while reset is held.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff           <= '0;
      state_ff.not_ready <= 1'b1;
      state_ff.mask      <= fault_irq_pkg::MASK_RESET;
      state_ff.irq_n     <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata  = state_ff.rdata;
  assign wake_irq_n = state_ff.irq_n;

  // ==========================================================================
  // Checks
  chk_corrupt_sets_ready:
  assert property (@(posedge clk) disable iff (sys_rst)
    (reg_corrupt || logic_supply_reset) |=> state_ff.not_ready)
    else $error("Not-ready flag missed its cause.");

  chk_not_ready_irq:
  assert property (@(posedge clk) disable iff (sys_rst)
    state_ff.not_ready |=> !wake_irq_n)
    else $error("Not-ready did not drive the interrupt output.");

  chk_read_clears_all:
  assert property (@(posedge clk) disable iff (sys_rst)
    (rd_event && triggers == 8'h00 && !reg_corrupt && !logic_supply_reset)
      |=> (ev_flags == fault_irq_pkg::EVENT_RESET))
    else $error("Event read did not clear all flags.");

  chk_flags_sticky:
  assert property (@(posedge clk) disable iff (sys_rst)
    !bank_clear |=> (($past(bank_flags) & ~bank_flags) == 8'h00))
    else $error("A flag dropped without a clearing read.");

  chk_read_returns_flags:
  assert property (@(posedge clk) disable iff (sys_rst)
    rd_event |=> (reg_rdata == $past(ev_flags)))
    else $error("Event read returned wrong data.");

  chk_wake_level_irq:
  assert property (@(posedge clk) disable iff (sys_rst)
    (bank_flags[fault_irq_pkg::BIT_WAKE] && !state_ff.mask[fault_irq_pkg::BIT_WAKE])
      |=> !wake_irq_n)
    else $error("Wake flag did not assert the output.");

  chk_wake_pulse_run:
  assert property (@(posedge clk) disable iff (sys_rst)
    pulse_start ##1 !reg_reset[*8]
      |-> ##1 !wake_irq_n)
    else $error("Wake pulse ended too early.");

  chk_mask_blocks:
  assert property (@(posedge clk) disable iff (sys_rst)
    (state_ff.mask[4:0] == fault_irq_pkg::SRC_ALL_MASK
      && state_ff.mask[fault_irq_pkg::BIT_WAKE]
      && !state_ff.not_ready && !pulse_active) |=> wake_irq_n)
    else $error("A masked source asserted the output.");

  chk_unmasked_asserts:
  assert property (@(posedge clk) disable iff (sys_rst)
    ((bank_flags[4:0] & ~state_ff.mask[4:0]) != 5'h00) |=> !wake_irq_n)
    else $error("Unmasked flag did not assert the output.");

  chk_line_level:
  assert property (@(posedge clk) disable iff (sys_rst)
    ##1 (state_ff.status[fault_irq_pkg::BIT_LINE] == $past(sense.line_low)))
    else $error("Line level status is wrong.");

  chk_fault_live:
  assert property (@(posedge clk) disable iff (sys_rst)
    sense.driver_fault |=> state_ff.status[fault_irq_pkg::BIT_DRV])
    else $error("Driver fault status missed.");

  chk_uv_hysteresis:
  assert property (@(posedge clk) disable iff (sys_rst)
    (state_ff.status[fault_irq_pkg::BIT_UV] && !sense.supply_above_uv_rise)
      |=> state_ff.status[fault_irq_pkg::BIT_UV])
    else $error("Undervoltage status left its hysteresis.");

  chk_tw_hysteresis:
  assert property (@(posedge clk) disable iff (sys_rst)
    (!state_ff.status[fault_irq_pkg::BIT_TW] && !sense.temp_above_warn_rise)
      |=> !state_ff.status[fault_irq_pkg::BIT_TW])
    else $error("Thermal warning status set without a rise.");

  chk_soft_reset:
  assert property (@(posedge clk) disable iff (sys_rst)
    (soft_rst && !reg_corrupt && !logic_supply_reset)
      |=> (state_ff.mask == fault_irq_pkg::MASK_RESET && !state_ff.not_ready))
    else $error("Soft reset left a register set.");

  chk_reserved_zero:
  assert property (@(posedge clk) disable iff (sys_rst)
    reg_req.rd |=> (reg_rdata[5] == 1'b0))
    else $error("Reserved bit read as one.");

  chk_mask_write_only:
  assert property (@(posedge clk) disable iff (sys_rst)
    (reg_req.wr && reg_req.addr != fault_irq_pkg::ADDR_MASK && !reg_reset)
      |=> $stable(state_ff.mask))
    else $error("Mask changed on a foreign write.");

  chk_aux_level:
  assert property (@(posedge clk) disable iff (sys_rst)
    ##1 (state_ff.status[fault_irq_pkg::BIT_AUX] == $past(sense.aux_low)))
    else $error("Aux level status is wrong.");

  chk_fault_clears:
  assert property (@(posedge clk) disable iff (sys_rst)
    !sense.driver_fault |=> !state_ff.status[fault_irq_pkg::BIT_DRV])
    else $error("Driver fault status latched.");

  chk_warn_live:
  assert property (@(posedge clk) disable iff (sys_rst)
    ##1 (state_ff.status[fault_irq_pkg::BIT_WARN]
      == $past(sense.supply_below_warn)))
    else $error("Supply warning status is wrong.");

  chk_uv_sets:
  assert property (@(posedge clk) disable iff (sys_rst)
    sense.supply_below_uv_fall |=> state_ff.status[fault_irq_pkg::BIT_UV])
    else $error("Undervoltage status missed.");

  chk_tsd_live:
  assert property (@(posedge clk) disable iff (sys_rst)
    ##1 (state_ff.status[fault_irq_pkg::BIT_TSD]
      == $past(sense.temp_above_shutdown)))
    else $error("Shutdown status is wrong.");

  chk_tw_sets:
  assert property (@(posedge clk) disable iff (sys_rst)
    sense.temp_above_warn_rise |=> state_ff.status[fault_irq_pkg::BIT_TW])
    else $error("Warning status missed.");

  chk_mask_stores:
  assert property (@(posedge clk) disable iff (sys_rst)
    (mask_wr && !reg_reset)
      |=> (state_ff.mask == ($past(reg_req.wdata) & fault_irq_pkg::MASK_WRITABLE)))
    else $error("Mask write did not store.");

  chk_pulse_drives:
  assert property (@(posedge clk) disable iff (sys_rst)
    pulse_active |=> !wake_irq_n)
    else $error("Wake pulse missed the output.");

  chk_irq_release:
  assert property (@(posedge clk) disable iff (sys_rst)
    (!state_ff.not_ready && bank_flags == 8'h00 && !pulse_active)
      |=> wake_irq_n)
    else $error("Output held with nothing pending.");

  chk_event_read_only:
  assert property (@(posedge clk) disable iff (sys_rst)
    (reg_req.wr && reg_req.addr == fault_irq_pkg::ADDR_EVENT
      && triggers == 8'h00 && !reg_reset) |=> $stable(bank_flags))
    else $error("A write changed the flags.");

endmodule

// ### verification/host_model.sv
// Host controller model that reaches the event, mask and status registers.
// Assumes clk is the block clock and that a request is taken on its rising edge.
module host_model (
  input  wire logic                 clk,
  input  wire logic [7:0]           reg_rdata,
  output fault_irq_pkg::reg_req_t   reg_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Idle bus
  // Strobes rest low; address and data rest on a pattern so stale values never look valid.
  initial begin
    reg_req = '{addr: 8'hA5, wr: 1'b0, rd: 1'b0, wdata: 8'h5A};
  end

  // ==========================================================================
  // Register cycles
  // One write, set up after an edge and held through the edge that takes it.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #10;
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(posedge clk);
    #10;
    reg_req.wr = 1'b0;
    reg_req.addr = ~a;
    reg_req.wdata = ~d;
  endtask

  // One read; the byte shows in the cycle after the taking edge.
  // The host learns of events only here, and a read of the event byte clears it.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #10;
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(posedge clk);
    #10;
    d = reg_rdata;
    reg_req.rd = 1'b0;
    reg_req.addr = ~a;
  endtask

  // Software reset through the mode register.
  task automatic soft_reset();
    write_reg(8'h04, 8'h80);
  endtask
endmodule

// ### verification/fault_event_latch_irq_tb_top.sv
// Self-checking bench for the event latch and wake/interrupt block.
// Assumes the host model drives the register port; the bench drives sense and reset causes.
module fault_event_latch_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned PULSE = 20;

  logic                    clk;
  logic                    sys_rst;
  fault_irq_pkg::reg_req_t reg_req;
  logic [7:0]              reg_rdata;
  fault_irq_pkg::sense_t   sense_v;
  logic                    logic_supply_reset;
  logic                    reg_corrupt;
  logic                    wake_irq_n;
  int                      err_total;
  int                      checked;

  // ==========================================================================
  // Clock, design and host
  // Clock of 100 ns period.
  initial clk = 1'b0;
  always #50 clk = ~clk;

  fault_event_latch_irq #(.WAKE_PULSE_CYCLES(PULSE)) i_fault_event_latch_irq (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .reg_req            (reg_req),
    .reg_rdata          (reg_rdata),
    .sense              (sense_v),
    .logic_supply_reset (logic_supply_reset),
    .reg_corrupt        (reg_corrupt),
    .wake_irq_n         (wake_irq_n)
  );

  host_model i_host_model (
    .clk       (clk),
    .reg_rdata (reg_rdata),
    .reg_req   (reg_req)
  );

  // ==========================================================================
  // Helpers
  // Waits n edges and lands just after the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  // Compares one byte and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Reads one register and compares it.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    i_host_model.read_reg(a, got);
    chk(got, exp);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Sense word with exactly one event source raised.
  function automatic fault_irq_pkg::sense_t one_src(input int i);
    fault_irq_pkg::sense_t s;
    s = '0;
    case (i)
      0: s.driver_fault = 1'b1;
      1: s.supply_below_warn = 1'b1;
      2: s.supply_below_uv_fall = 1'b1;
      3: s.temp_above_shutdown = 1'b1;
      4: s.temp_above_warn_rise = 1'b1;
      default: s.wake_detect = 1'b1;
    endcase
    return s;
  endfunction

  // Event and mask bit of each source: 4, 3, 2, 1, 0, then wake-up at 6.
  function automatic logic [7:0] src_bit(input int i);
    return (i == 5) ? 8'h40 : (8'h01 << (4 - i));
  endfunction

  // Expected live status byte from the sense word and the two hysteresis states.
  function automatic logic [7:0] st_exp(input fault_irq_pkg::sense_t s, input logic uv,
                                        input logic tw);
    return {s.line_low, s.aux_low, 1'b0, s.driver_fault, s.supply_below_warn, uv,
            s.temp_above_shutdown, tw};
  endfunction

  // ==========================================================================
  // Watchdog
  // Cuts a hang short well beyond the few hundred cycles the tests need.
  initial begin
    #2_000_000;
    err_total++;
    conclude();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    int         v;
    int         t;
    logic       uv_e;
    logic       tw_e;
    sys_rst = 1'b1;
    sense_v = '0;
    logic_supply_reset = 1'b0;
    reg_corrupt = 1'b0;
    err_total = 0;
    checked = 0;
    void'($urandom(32'h51a5_520b));
    repeat (6) @(posedge clk);
    #10;
    sys_rst = 1'b0;
    // Power-up: not-ready pulls the output even with every mask bit set.
    cyc(3);
    chk({7'h00, wake_irq_n}, 8'h00);
    rdchk(8'h01, 8'h00);
    i_host_model.write_reg(8'h01, 8'hFF);
    cyc(2);
    chk({7'h00, wake_irq_n}, 8'h00);
    rdchk(8'h01, 8'h5F);
    rdchk(8'h00, 8'h80);
    cyc(1);
    chk({7'h00, wake_irq_n}, 8'h01);
    rdchk(8'h02, 8'h00);
    // Random mask values; reserved bits must read zero.
    repeat (6) begin
      d = 8'($urandom);
      i_host_model.write_reg(8'h01, d);
      rdchk(8'h01, d & 8'h5F);
    end
    i_host_model.write_reg(8'h01, 8'h00);
    // Writes to read-only places and reads of unmapped places.
    i_host_model.write_reg(8'h00, 8'hFF);
    i_host_model.write_reg(8'h02, 8'hFF);
    rdchk(8'h00, 8'h00);
    rdchk(8'h04, 8'h00);
    rdchk(8'h07, 8'h00);
    // Each source unmasked, then each source but wake-up masked.
    for (int i = 0; i < 6; i++) begin
      sense_v = one_src(i);
      cyc(3);
      chk({7'h00, wake_irq_n}, 8'h00);
      sense_v = '0;
      rdchk(8'h00, src_bit(i));
      cyc(1);
      chk({7'h00, wake_irq_n}, 8'h01);
      rdchk(8'h00, 8'h00);
      if (i < 5) begin
        i_host_model.write_reg(8'h01, src_bit(i));
        sense_v = one_src(i);
        cyc(3);
        chk({7'h00, wake_irq_n}, 8'h01);
        sense_v = '0;
        rdchk(8'h00, src_bit(i));
        i_host_model.write_reg(8'h01, 8'h00);
      end
    end
    // Pulse mode: output low for the pulse length only, flag still latched.
    i_host_model.write_reg(8'h01, 8'h40);
    sense_v.wake_detect = 1'b1;
    cyc(1);
    sense_v = '0;
    v = 0;
    repeat (30) begin
      cyc(1);
      if (wake_irq_n === 1'b0) v++;
    end
    chk(8'(v), 8'(PULSE));
    rdchk(8'h00, 8'h40);
    // Software reset in the middle of a pending event.
    i_host_model.write_reg(8'h01, 8'h1F);
    sense_v.supply_below_warn = 1'b1;
    cyc(2);
    sense_v = '0;
    i_host_model.soft_reset();
    rdchk(8'h01, 8'h00);
    rdchk(8'h00, 8'h00);
    chk({7'h00, wake_irq_n}, 8'h01);
    // Logic-supply register reset and corruption both raise not-ready.
    for (int k = 0; k < 2; k++) begin
      i_host_model.write_reg(8'h01, 8'h1F);
      if (k == 0) logic_supply_reset = 1'b1;
      else reg_corrupt = 1'b1;
      cyc(1);
      logic_supply_reset = 1'b0;
      reg_corrupt = 1'b0;
      cyc(2);
      chk({7'h00, wake_irq_n}, 8'h00);
      rdchk(8'h00, 8'h80);
    end
    i_host_model.write_reg(8'h01, 8'h00);
    // Live status with random levels; the sense word changes in one step.
    for (int k = 0; k < 24; k++) begin
      fault_irq_pkg::sense_t s;
      v = (k == 0) ? 2 : $urandom_range(2, 0);
      t = (k == 0) ? 2 : $urandom_range(2, 0);
      s = '0;
      s.line_low = 1'($urandom);
      s.aux_low = 1'($urandom);
      s.driver_fault = 1'($urandom);
      s.supply_below_uv_fall = (v == 0);
      s.supply_above_uv_rise = (v == 2);
      s.supply_below_warn = (v < 2) | 1'($urandom);
      s.temp_above_warn_rise = (t == 0);
      s.temp_below_warn_fall = (t == 2);
      s.temp_above_shutdown = (t == 0) & 1'($urandom);
      sense_v = s;
      if (v == 0) uv_e = 1'b1;
      else if (v == 2) uv_e = 1'b0;
      if (t == 0) tw_e = 1'b1;
      else if (t == 2) tw_e = 1'b0;
      i_host_model.write_reg(8'h02, 8'hFF);
      rdchk(8'h02, st_exp(s, uv_e, tw_e));
    end
    i_host_model.read_reg(8'h00, d);
    conclude();
  end
endmodule
